// [hw/stc_pkg.sv]
package stc_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int FINE_UNIT_NS = 1000000;
    localparam int FINE_UNIT_CYC = FINE_UNIT_NS / CLK_PERIOD_NS;
    localparam int COARSE_UNIT_MS = 100;
    localparam int NUM_ENTRIES = 2048;
    localparam int RESERVED_FIRST = 1920;
    localparam int NUM_DATA = 8;
    localparam logic [15:0] SET_MAX = 16'h7fff;
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_SEL = 8'h04;
    localparam logic [7:0] ADDR_VALUE = 8'h08;
    localparam logic [7:0] ADDR_SCAN = 8'h0c;
    localparam logic [7:0] ADDR_DATA = 8'h20;
    localparam int SEL_KIND_BIT = 11;

    typedef enum logic [2:0] {
        OP_NOP = 3'h0,
        OP_COARSE = 3'h1,
        OP_FINE = 3'h2,
        OP_COUNT = 3'h3,
        OP_RST_TIMER = 3'h4,
        OP_RST_COUNT = 3'h5,
        OP_END_SCAN = 3'h6
    } stc_op_t;

    typedef enum logic [1:0] {
        ST_INIT = 2'h0,
        ST_IDLE = 2'h1,
        ST_SWEEP = 2'h3
    } stc_state_t;

    typedef struct packed {
        logic [14:0] setting;
        logic [10:0] index;
        logic fromData;
        logic accum;
        logic contact;
        stc_op_t op;
    } stc_cmd_t;

    typedef struct packed {
        logic unit;
        logic active;
        logic done;
    } stc_tflag_t;
endpackage

// [hw/stc_unit.sv]
`timescale 1ns/1ps
module stc_unit #(
    parameter int FINE_CYCLES = stc_pkg::FINE_UNIT_CYC
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    localparam int N = stc_pkg::NUM_ENTRIES;

    stc_pkg::stc_state_t state;
    stc_pkg::stc_cmd_t cmd;
    logic [10:0] walkIdx;
    logic [31:0] divCnt;
    logic [6:0] coarseDiv;
    logic fineTick, coarseTick;
    logic [15:0] fineNow, coarseNow, scanId;
    logic [11:0] sel;
    logic [15:0] dataReg [stc_pkg::NUM_DATA];
    logic [15:0] tCur [N];
    logic [15:0] tSet [N];
    logic [15:0] tStamp [N];
    stc_pkg::stc_tflag_t tFlag [N];
    logic [15:0] cCur [N];
    logic [15:0] cScan [N];
    logic cPrev [N];
    logic cNew [N];
    logic cOld [N];

    // Contacts are kept lazily: a stamp of the scan that last changed
    // them avoids walking all counters at every end of scan. A counter
    // left untouched for exactly 65536 scans can show a stale contact.
    function automatic logic cntVisible(input logic [10:0] i);
        cntVisible = cScan[i] == scanId ? cOld[i] : cNew[i];
    endfunction

    assign fineTick = divCnt == 32'(FINE_CYCLES - 1);
    assign coarseTick = fineTick
        && coarseDiv == 7'(stc_pkg::COARSE_UNIT_MS - 1);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            divCnt <= 32'h0;
        end else if (fineTick) begin
            divCnt <= 32'h0;
        end else begin
            divCnt <= divCnt + 32'h1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            coarseDiv <= 7'h0;
            fineNow <= 16'h0;
            coarseNow <= 16'h0;
        end else if (fineTick) begin
            fineNow <= fineNow + 16'h1;
            if (coarseTick) begin
                coarseDiv <= 7'h0;
                coarseNow <= coarseNow + 16'h1;
            end else begin
                coarseDiv <= coarseDiv + 7'h1;
            end
        end
    end

    logic access, busy, isCmd, isSel, isValue, isScan, isData, mapped;
    logic wrEn, cmdFire;
    logic [31:0] rdVal;

    assign cmd = stc_pkg::stc_cmd_t'(pwdata);
    assign busy = state != stc_pkg::ST_IDLE;
    assign access = psel && penable;
    assign isCmd = paddr == stc_pkg::ADDR_CMD;
    assign isSel = paddr == stc_pkg::ADDR_SEL;
    assign isValue = paddr == stc_pkg::ADDR_VALUE;
    assign isScan = paddr == stc_pkg::ADDR_SCAN;
    assign isData = paddr[7:5] == stc_pkg::ADDR_DATA[7:5]
        && paddr[1:0] == 2'h0;
    assign mapped = isCmd || isSel || isValue || isScan || isData;
    // Commands wait while the unit walks its tables.
    assign pready = !(busy && isCmd && pwrite);
    assign pslverr = access && !mapped;
    assign wrEn = access && pwrite && pready && mapped;
    assign cmdFire = wrEn && isCmd;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sel <= 12'h0;
        end else if (wrEn && isSel) begin
            sel <= pwdata[11:0];
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < stc_pkg::NUM_DATA; i++) begin
                dataReg[i] <= 16'h0;
            end
        end else if (wrEn && isData) begin
            dataReg[paddr[4:2]] <= pwdata[15:0];
        end
    end

    always_comb begin
        rdVal = 32'h0;
        if (isValue) begin
            if (sel[stc_pkg::SEL_KIND_BIT]) begin
                rdVal = {15'h0, cntVisible(sel[10:0]), cCur[sel[10:0]]};
            end else begin
                rdVal = {14'h0, !tFlag[sel[10:0]].done,
                    tFlag[sel[10:0]].done, tCur[sel[10:0]]};
            end
        end else if (isScan) begin
            rdVal = {15'h0, busy, scanId};
        end else if (isSel) begin
            rdVal = {20'h0, sel};
        end else if (isData) begin
            rdVal = {16'h0, dataReg[paddr[4:2]]};
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdVal;
        end
    end

    logic [15:0] rawSet, effSet, cntSet;

    always_comb begin
        rawSet = {1'b0, cmd.setting};
        if (cmd.fromData) begin
            rawSet = dataReg[cmd.setting[2:0]];
        end
        effSet = rawSet > stc_pkg::SET_MAX ? stc_pkg::SET_MAX : rawSet;
        cntSet = effSet == 16'h0 ? 16'h1 : effSet;
    end

    logic timerOp, walkAct, tUnit, tOn;
    logic [10:0] tIdx;
    logic [15:0] tLimit, tNow, tElapsed, tNextCur;
    logic [16:0] tSum;
    stc_pkg::stc_tflag_t tOld, tNext;

    assign timerOp = cmdFire && (cmd.op == stc_pkg::OP_COARSE
        || cmd.op == stc_pkg::OP_FINE);
    assign tIdx = state == stc_pkg::ST_IDLE ? cmd.index : walkIdx;
    assign tOld = tFlag[tIdx];
    assign walkAct = state == stc_pkg::ST_SWEEP && tOld.active
        && !tOld.done;
    assign tUnit = walkAct ? tOld.unit : cmd.op == stc_pkg::OP_FINE;
    assign tOn = walkAct || cmd.contact;
    assign tLimit = walkAct ? tSet[tIdx] : effSet;
    assign tNow = tUnit ? fineNow : coarseNow;
    // Time is counted only while running in one unit; a unit change
    // restarts the stamp instead of mixing the two bases.
    assign tElapsed = tOld.active && tUnit == tOld.unit
        ? tNow - tStamp[tIdx] : 16'h0;
    assign tSum = {1'b0, tCur[tIdx]} + {1'b0, tElapsed};

    always_comb begin
        tNext = '{unit: tUnit, active: tOn, done: 1'b0};
        tNextCur = tCur[tIdx];
        if (!tOn) begin
            if (!cmd.accum) begin
                tNextCur = 16'h0;
            end
        end else if (tOld.done) begin
            tNext.done = 1'b1;
        end else if (tSum >= {1'b0, tLimit}) begin
            tNextCur = tLimit;
            tNext.done = 1'b1;
        end else begin
            tNextCur = tSum[15:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (state == stc_pkg::ST_INIT) begin
            tCur[walkIdx] <= 16'h0;
            tFlag[walkIdx] <= '0;
        end else if (timerOp || walkAct) begin
            tCur[tIdx] <= tNextCur;
            tFlag[tIdx] <= tNext;
            tStamp[tIdx] <= tNow;
            if (timerOp) begin
                tSet[tIdx] <= tLimit;
            end
        end else if (cmdFire && cmd.op == stc_pkg::OP_RST_TIMER) begin
            tCur[tIdx] <= 16'h0;
            tFlag[tIdx] <= '0;
        end
    end

    logic cntOp, cntAny, cRise, cDone;
    logic [15:0] cNextCur;

    assign cntOp = cmdFire && cmd.op == stc_pkg::OP_COUNT;
    assign cntAny = cntOp || (cmdFire && cmd.op == stc_pkg::OP_RST_COUNT);
    assign cRise = cmd.contact && !cPrev[cmd.index];

    always_comb begin
        cNextCur = cCur[cmd.index];
        if (cmd.op == stc_pkg::OP_RST_COUNT) begin
            cNextCur = 16'h0;
        end else if (cRise && cCur[cmd.index] >= cntSet) begin
            cNextCur = cntSet;
        end else if (cRise) begin
            cNextCur = cCur[cmd.index] + 16'h1;
        end
    end
    assign cDone = cmd.op == stc_pkg::OP_COUNT && cNextCur == cntSet;

    always_ff @(posedge sys_clk) begin
        if (state == stc_pkg::ST_INIT) begin
            cCur[walkIdx] <= 16'h0;
            cPrev[walkIdx] <= 1'b0;
            cNew[walkIdx] <= 1'b0;
            cOld[walkIdx] <= 1'b0;
            cScan[walkIdx] <= 16'h0;
        end else if (cntAny) begin
            cCur[cmd.index] <= cNextCur;
            if (cntOp) begin
                cPrev[cmd.index] <= cmd.contact;
            end
            if (cScan[cmd.index] != scanId) begin
                cOld[cmd.index] <= cNew[cmd.index];
                cScan[cmd.index] <= scanId;
            end
            cNew[cmd.index] <= cDone;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            scanId <= 16'h0;
        end else if (cmdFire && cmd.op == stc_pkg::OP_END_SCAN) begin
            scanId <= scanId + 16'h1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state <= stc_pkg::ST_INIT;
            walkIdx <= 11'h0;
        end else begin
            case (state)
                stc_pkg::ST_INIT: begin
                    walkIdx <= walkIdx + 11'h1;
                    if (walkIdx == 11'(N - 1)) begin
                        state <= stc_pkg::ST_IDLE;
                    end
                end
                stc_pkg::ST_IDLE: begin
                    if (cmdFire && cmd.op == stc_pkg::OP_END_SCAN) begin
                        state <= stc_pkg::ST_SWEEP;
                        walkIdx <= 11'(stc_pkg::RESERVED_FIRST);
                    end
                end
                stc_pkg::ST_SWEEP: begin
                    walkIdx <= walkIdx + 11'h1;
                    if (walkIdx == 11'(N - 1)) begin
                        state <= stc_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= stc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    logic [10:0] aIdx;
    logic [15:0] aCur, aLim;
    logic aVis;

    always_ff @(posedge sys_clk) begin
        aIdx <= cmd.index;
        aCur <= cmd.op == stc_pkg::OP_COUNT ? cCur[cmd.index] : tCur[tIdx];
        aLim <= cmd.op == stc_pkg::OP_COUNT ? cntSet : tLimit;
        aVis <= cntVisible(cmd.index);
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    a_coarse_step: assert property (
        coarseTick |=> coarseNow == $past(coarseNow) + 16'h1
            && coarseDiv == 7'h0)
        else $error("coarse unit step broken");
    a_fine_spacing: assert property (
        fineTick |=> !fineTick ##0 divCnt == 32'h0)
        else $error("fine unit ticks too close");
    a_walk_reserved: assert property (
        state == stc_pkg::ST_SWEEP |-> walkIdx >= 11'(stc_pkg::RESERVED_FIRST))
        else $error("end-of-scan walk left the reserved timers");
    a_sweep_length: assert property (
        cmdFire && cmd.op == stc_pkg::OP_END_SCAN |=>
            state == stc_pkg::ST_SWEEP ##127 state == stc_pkg::ST_SWEEP
            ##1 state == stc_pkg::ST_IDLE)
        else $error("end-of-scan walk has wrong length");
    a_accum_hold: assert property (
        timerOp && !cmd.contact && cmd.accum |=> tCur[aIdx] == aCur)
        else $error("accumulating timer lost its value");
    a_off_output: assert property (
        timerOp && !cmd.contact |=> !tFlag[aIdx].done)
        else $error("timer output stayed on with condition off");
    a_timer_limit: assert property (
        timerOp && cmd.contact |=> tCur[aIdx] <= aLim || tFlag[aIdx].done)
        else $error("timer ran past its setting");
    a_timer_match: assert property (
        timerOp && cmd.contact && !tOld.done && tLimit != 16'h0 |=>
            tFlag[aIdx].done == (tCur[aIdx] == aLim))
        else $error("timer output disagrees with match");
    a_count_bound: assert property (
        cntOp |=> cCur[aIdx] <= aLim && cCur[aIdx] <= aCur + 16'h1)
        else $error("counter stepped too far");
    a_count_reset: assert property (
        cmdFire && cmd.op == stc_pkg::OP_RST_COUNT |=>
            cCur[aIdx] == 16'h0 && !cNew[aIdx])
        else $error("counter reset incomplete");
    a_contact_defer: assert property (
        cntOp |=> cntVisible(aIdx) == aVis)
        else $error("counter contact changed inside the scan");

    c_sweep_done: cover property (
        state == stc_pkg::ST_SWEEP ##1 state == stc_pkg::ST_IDLE);
    c_count_hits: cover property (cntOp && cDone);
    c_timer_fires: cover property (timerOp && tNext.done && !tOld.done);
endmodule

// [dv/stc_program.sv]
`timescale 1ns/1ps
// Only reserved timers are left to advance at end of scan.
module stc_program (
    input wire logic sys_clk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic hung
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        hung = 1'b0;
    end

    // The request stands until pready is seen high at a rising edge.
    // A stall past the bound is reported as a hang.
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic err);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1 && n < 5000) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 5000) begin
            hung <= 1'b1;
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// [dv/stc_unit_bench.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checksDone++; if ((got) !== (ex)) begin \
    nFail++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module stc_unit_bench;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, hung, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, v, u, w;
    int nFail = 0;
    int checksDone = 0;

    always #10 sys_clk = ~sys_clk;

    // A short fine unit keeps the coarse unit at 400 cycles.
    stc_unit #(.FINE_CYCLES(4)) i_stc_unit (.sys_clk(sys_clk),
        .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    stc_program i_stc_program (.sys_clk(sys_clk), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .hung(hung));

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        i_stc_program.xfer(1'b0, a, 32'h0, q, err);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        i_stc_program.xfer(1'b1, a, d, q, err);
    endtask
    task automatic cmd(input stc_pkg::stc_op_t op, input int idx,
        input int st, input logic on, input logic acc, input logic fd);
        stc_pkg::stc_cmd_t c;
        c.op = op;
        c.contact = on;
        c.accum = acc;
        c.fromData = fd;
        c.index = 11'(idx);
        c.setting = 15'(st);
        wr(stc_pkg::ADDR_CMD, c);
    endtask
    task automatic fine(input int idx, input int st, input logic on,
        input logic acc);
        cmd(stc_pkg::OP_FINE, idx, st, on, acc, 1'b0);
    endtask
    task automatic look(input logic kind, input int idx);
        wr(stc_pkg::ADDR_SEL, {20'h0, kind, 11'(idx)});
        rd(stc_pkg::ADDR_VALUE, v);
    endtask
    task automatic edges(input int idx, input int st, input int n,
        input logic fd);
        for (int k = 0; k < n; k++) begin
            cmd(stc_pkg::OP_COUNT, idx, st, 1'b0, 1'b0, fd);
            cmd(stc_pkg::OP_COUNT, idx, st, 1'b1, 1'b0, fd);
        end
    endtask
    // Waiting out the 128-cycle walk keeps later reads free of it.
    task automatic endscan;
        cmd(stc_pkg::OP_END_SCAN, 0, 0, 1'b0, 1'b0, 1'b0);
        repeat (140) @(posedge sys_clk);
    endtask
    task automatic end_of_test;
        if (nFail == 0 && checksDone > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge hung) begin
        nFail++;
        end_of_test();
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        w = 32'h0001_0000;
        for (int n = 0; n < 1000 && w[16] !== 1'b0; n++) begin
            rd(stc_pkg::ADDR_SCAN, w);
        end
        `CHK("init busy", 1'b0, w[16])
        rd(8'h10, w);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0, w)
        wr(stc_pkg::ADDR_DATA + 8'h08, 32'h2);
        rd(stc_pkg::ADDR_DATA + 8'h08, w);
        `CHK("data2", 32'h2, w)
        edges(5, 3, 1, 1'b0);
        cmd(stc_pkg::OP_COUNT, 5, 3, 1'b1, 1'b0, 1'b0);
        look(1'b1, 5);
        `CHK("c5 one edge", 16'd1, v[15:0])
        edges(5, 3, 4, 1'b0);
        look(1'b1, 5);
        `CHK("c5 stop", 16'd3, v[15:0])
        `CHK("c5 before end", 1'b0, v[16])
        rd(stc_pkg::ADDR_SCAN, w);
        endscan();
        look(1'b1, 5);
        `CHK("c5 contact", 1'b1, v[16])
        rd(stc_pkg::ADDR_SCAN, u);
        `CHK("scan count", w[15:0] + 16'd1, u[15:0])
        cmd(stc_pkg::OP_RST_COUNT, 5, 3, 1'b0, 1'b0, 1'b0);
        look(1'b1, 5);
        `CHK("c5 cleared", 16'd0, v[15:0])
        `CHK("c5 held", 1'b1, v[16])
        endscan();
        look(1'b1, 5);
        `CHK("c5 off", 1'b0, v[16])
        edges(6, 0, 1, 1'b0);
        edges(7, 2, 3, 1'b1);
        endscan();
        look(1'b1, 6);
        `CHK("c6 zero set", 17'h1_0001, v[16:0])
        look(1'b1, 7);
        `CHK("c7 data set", 17'h1_0002, v[16:0])
        fine(10, 100, 1'b1, 1'b0);
        repeat (40) @(posedge sys_clk);
        fine(10, 100, 1'b1, 1'b0);
        look(1'b0, 10);
        `CHK("fine unit", 1'b1, v[15:0] >= 9 && v[15:0] <= 12)
        `CHK("fine running", 1'b0, v[16])
        fine(12, 5, 1'b1, 1'b0);
        repeat (40) @(posedge sys_clk);
        fine(12, 5, 1'b1, 1'b0);
        look(1'b0, 12);
        `CHK("t12 done", 18'h1_0005, v[17:0])
        fine(12, 5, 1'b0, 1'b0);
        look(1'b0, 12);
        `CHK("t12 off", 1'b0, v[16])
        `CHK("t12 clear", 16'd0, v[15:0])
        fine(12, 5, 1'b1, 1'b0);
        look(1'b0, 12);
        `CHK("t12 restart", 18'h2_0000, v[17:0])
        fine(30, 3, 1'b1, 1'b0);
        fine(30, 50, 1'b1, 1'b0);
        repeat (40) @(posedge sys_clk);
        fine(30, 50, 1'b1, 1'b0);
        fine(30, 3, 1'b1, 1'b0);
        look(1'b0, 30);
        `CHK("t30 first set", 17'h1_0003, v[16:0])
        cmd(stc_pkg::OP_RST_TIMER, 30, 0, 1'b0, 1'b0, 1'b0);
        look(1'b0, 30);
        `CHK("t30 reset", 18'h2_0000, v[17:0])
        fine(20, 100, 1'b1, 1'b1);
        repeat (40) @(posedge sys_clk);
        fine(20, 100, 1'b1, 1'b1);
        fine(20, 100, 1'b0, 1'b1);
        look(1'b0, 20);
        u = v;
        `CHK("acc kept", 1'b1, u[15:0] >= 9 && u[15:0] <= 14)
        repeat (80) @(posedge sys_clk);
        fine(20, 100, 1'b1, 1'b1);
        repeat (40) @(posedge sys_clk);
        fine(20, 100, 1'b1, 1'b1);
        look(1'b0, 20);
        w = v - u;
        `CHK("acc resume", 1'b1, w[15:0] >= 9 && w[15:0] <= 14)
        cmd(stc_pkg::OP_COARSE, 11, 2, 1'b1, 1'b0, 1'b0);
        repeat (600) @(posedge sys_clk);
        cmd(stc_pkg::OP_COARSE, 11, 2, 1'b1, 1'b0, 1'b0);
        look(1'b0, 11);
        `CHK("coarse unit", 1'b1, v[15:0] >= 1 && v[15:0] <= 2)
        repeat (400) @(posedge sys_clk);
        cmd(stc_pkg::OP_COARSE, 11, 2, 1'b1, 1'b0, 1'b0);
        look(1'b0, 11);
        `CHK("coarse done", 18'h1_0002, v[17:0])
        fine(1925, 3, 1'b1, 1'b0);
        fine(40, 3, 1'b1, 1'b0);
        repeat (40) @(posedge sys_clk);
        endscan();
        look(1'b0, 1925);
        `CHK("reserved at end", 17'h1_0003, v[16:0])
        look(1'b0, 40);
        `CHK("general at end", 17'h0_0000, v[16:0])
        end_of_test();
    end
endmodule
